// >>> hdl/serial_port_pkg.sv
package serial_port_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets.
    localparam logic [7:0] OFS_SERIAL_CONTROL = 8'h98;
    localparam logic [7:0] OFS_POWER_CONTROL = 8'h8F;
    localparam logic [7:0] OFS_SERIAL_DATA = 8'h9A;
    localparam logic [7:0] OFS_STATION_ADDRESS = 8'hA9;
    localparam logic [7:0] OFS_STATION_MASK = 8'hB9;
    localparam logic [7:0] OFS_RX_BAUD_DIV = 8'h9C;
    localparam logic [7:0] OFS_TX_BAUD_DIV = 8'h9D;

    // Serial control register fields.
    localparam int SC_BIT7 = 7;
    localparam int SC_MODE_BIT1 = 6;
    localparam int SC_MULTIPROC = 5;
    localparam int SC_RX_ENABLE = 4;
    localparam int SC_TX_NINTH = 3;
    localparam int SC_RX_NINTH = 2;
    localparam int SC_TX_DONE = 1;
    localparam int SC_RX_DONE = 0;

    // Power control register field.
    localparam int PC_FRAME_CHECK = 6;

    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_BAUD_DIV = 8'h00;

    // Bit timing: sixteen ticks per bit, sampled at the middle tick.
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] TICK_MID = 4'h7;

    // Serial modes.
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_UART8 = 2'h1;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b11,
        RX_STOP = 2'b10
    } rx_state_t;

endpackage

// >>> hdl/serial_rx_if.sv
interface serial_rx_if;
    logic [7:0] div;
    logic nine_bit;
    logic enable;
    logic [7:0] data;
    logic ninth;
    logic stop_bit;
    logic data_pulse;
    logic stop_pulse;

    modport framer (input div, input nine_bit, input enable,
                    output data, output ninth, output stop_bit, output data_pulse, output stop_pulse);
    modport ctrl (output div, output nine_bit, output enable,
                  input data, input ninth, input stop_bit, input data_pulse, input stop_pulse);
endinterface

// >>> hdl/serial_rx_framer.sv
module serial_rx_framer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic rxd,
    serial_rx_if.framer rx
);
    import serial_port_pkg::*;

    rx_state_t state_r;
    logic [7:0] presc_r;
    logic [3:0] sub_r;
    logic [3:0] bitn_r;
    logic [8:0] shift_r;
    logic [8:0] shift_nxt;
    logic tick;
    logic [3:0] last_bit;

    assign tick = (presc_r == rx.div);
    assign shift_nxt = {rxd, shift_r[8:1]};
    assign last_bit = rx.nine_bit ? 4'h8 : 4'h7;

    // Divides the clock down to sixteen ticks per bit.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            presc_r <= RST_BYTE;
        end else if (tick || state_r == RX_IDLE) begin
            presc_r <= RST_BYTE;
        end else begin
            presc_r <= presc_r + 8'h01;
        end
    end

    // Frame sequencer: start check at mid start bit, then one sample per bit.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= RX_IDLE;
            sub_r <= 4'h0;
            bitn_r <= 4'h0;
            shift_r <= 9'h000;
            rx.data <= RST_BYTE;
            rx.ninth <= 1'b0;
            rx.stop_bit <= 1'b0;
            rx.data_pulse <= 1'b0;
            rx.stop_pulse <= 1'b0;
        end else begin
            rx.data_pulse <= 1'b0;
            rx.stop_pulse <= 1'b0;
            case (state_r)
                RX_IDLE: begin
                    sub_r <= 4'h0;
                    bitn_r <= 4'h0;
                    if (rx.enable && !rxd) begin
                        state_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (tick) begin
                        sub_r <= sub_r + 4'h1;
                        if (sub_r == TICK_MID) begin
                            sub_r <= 4'h0;
                            state_r <= rxd ? RX_IDLE : RX_DATA;
                        end
                    end
                end
                RX_DATA: begin
                    if (tick) begin
                        sub_r <= sub_r + 4'h1;
                        if (sub_r == TICK_LAST) begin
                            shift_r <= shift_nxt;
                            bitn_r <= bitn_r + 4'h1;
                            if (bitn_r == last_bit) begin
                                rx.data <= rx.nine_bit ? shift_nxt[7:0] : shift_nxt[8:1];
                                rx.ninth <= rx.nine_bit ? shift_nxt[8] : 1'b0;
                                rx.data_pulse <= 1'b1;
                                state_r <= RX_STOP;
                            end
                        end
                    end
                end
                RX_STOP: begin
                    if (tick) begin
                        sub_r <= sub_r + 4'h1;
                        if (sub_r == TICK_LAST) begin
                            rx.stop_bit <= rxd;
                            rx.stop_pulse <= 1'b1;
                            state_r <= RX_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= RX_IDLE;
                end
            endcase
        end
    end

endmodule // serial_rx_framer

// >>> hdl/serial_port.sv
// Notes on behaviour
// - Stop-bit checking only in modes 1 to 3, and only with frame check enabled.
// - With checking on, a bad stop bit sets the framing error flag.
// - Framing error stays set until software clears it or reset; good frames never clear.
// - With checking on, receive-done rises at the stop bit, not the last data bit.
// - Control bit 7 is the framing error flag with checking on, else mode bit 0.
// - Address recognition is on while the multiprocessor enable bit is set, outside mode 0.
// - With recognition on, only matching address frames raise receive-done; others dropped.
// - Mode 1 with recognition: stop bit is the ninth bit; needs match and valid stop.
// - In mode 0 the multiprocessor enable bit has no effect at all.
// - Given address: station address with zero mask bits as don't-care.
// - Broadcast address: address OR mask, zero bits of that OR are don't-care.
// - An address frame is accepted on a given or broadcast match.
// - Reset clears station address and mask, so any address is accepted.
// - Asynchronous modes are full duplex, with separate transmit and receive baud rates.
// - Modes 2 and 3 store the ninth bit; mode 1 without recognition stores the stop bit.
//
// Decided for this implementation: the address-and-strobe port.
module serial_port (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [serial_port_pkg::ADDR_W-1:0] addr,
    input wire logic [serial_port_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [serial_port_pkg::DATA_W-1:0] rd_data,
    input wire logic rxd,
    output logic txd,
    output logic rx_done,
    output logic tx_done
);
    import serial_port_pkg::*;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // Address match against one address byte and its mask.
    function automatic logic addr_match(input logic [7:0] rx_byte, input logic [7:0] adr, input logic [7:0] msk);
        addr_match = ((rx_byte ^ adr) & msk) == 8'h00;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    logic serial_mode_bit0_r;
    logic serial_mode_bit1_r;
    logic multiproc_enable_r;
    logic ren_r;
    logic tb8_r;
    logic rx_ninth_bit_r;
    logic ti_r;
    logic rx_done_flag_r;
    logic framing_error_flag_r;
    logic fce_r;
    logic [7:0] rx_buf_r;
    logic [7:0] station_address_r;
    logic [7:0] station_address_mask_r;
    logic [7:0] rx_div_r;
    logic [7:0] tx_div_r;
    logic [1:0] mode;
    logic mp_active;
    logic ctrl_wr;
    logic sw_data;
    logic [7:0] ctrl_view;

    serial_rx_if rx ();

    serial_rx_framer u_framer (
        .mclk(mclk),
        .rst(rst),
        .rxd(rxd),
        .rx(rx.framer)
    );

    assign mode = {serial_mode_bit0_r, serial_mode_bit1_r};
    assign mp_active = multiproc_enable_r && (mode != MODE_SHIFT);
    assign ctrl_wr = wr_en && (addr == OFS_SERIAL_CONTROL);
    assign sw_data = wr_en && (addr == OFS_SERIAL_DATA);
    assign ctrl_view = {fce_r ? framing_error_flag_r : serial_mode_bit0_r, serial_mode_bit1_r, multiproc_enable_r,
                        ren_r, tb8_r, rx_ninth_bit_r, ti_r, rx_done_flag_r};

    assign rx.div = rx_div_r;
    assign rx.nine_bit = mode[1];
    assign rx.enable = ren_r && (mode != MODE_SHIFT);

    ////////////////////////////////////////////////////////////////////////////////
    // Address recognition.

    logic [7:0] bcast_addr;
    logic given_hit;
    logic bcast_hit;
    logic addr_hit;
    logic addr_frame;
    logic use_stop;
    logic rx_event;
    logic rx_accept;

    assign bcast_addr = station_address_r | station_address_mask_r;
    assign given_hit = addr_match(rx.data, station_address_r, station_address_mask_r);
    assign bcast_hit = addr_match(rx.data, bcast_addr, bcast_addr);
    assign addr_hit = given_hit || bcast_hit;
    assign addr_frame = (mode == MODE_UART8) ? rx.stop_bit : rx.ninth;
    assign use_stop = fce_r || (mp_active && mode == MODE_UART8);
    assign rx_event = use_stop ? rx.stop_pulse : rx.data_pulse;
    assign rx_accept = rx_event && (!mp_active || (addr_frame && addr_hit));

    ////////////////////////////////////////////////////////////////////////////////
    // Control register and flags.

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            serial_mode_bit0_r <= 1'b0;
            serial_mode_bit1_r <= 1'b0;
            multiproc_enable_r <= 1'b0;
            ren_r <= 1'b0;
            tb8_r <= 1'b0;
        end else if (ctrl_wr) begin
            if (!fce_r) begin
                serial_mode_bit0_r <= wr_data[SC_BIT7];
            end
            serial_mode_bit1_r <= wr_data[SC_MODE_BIT1];
            multiproc_enable_r <= wr_data[SC_MULTIPROC];
            ren_r <= wr_data[SC_RX_ENABLE];
            tb8_r <= wr_data[SC_TX_NINTH];
        end
    end

    // Hardware sets win over a software clear in the same cycle.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            framing_error_flag_r <= 1'b0;
        end else if (rx.stop_pulse && fce_r && !rx.stop_bit) begin
            framing_error_flag_r <= 1'b1;
        end else if (ctrl_wr && fce_r) begin
            framing_error_flag_r <= wr_data[SC_BIT7];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_done_flag_r <= 1'b0;
        end else if (rx_accept) begin
            rx_done_flag_r <= 1'b1;
        end else if (ctrl_wr) begin
            rx_done_flag_r <= wr_data[SC_RX_DONE];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_ninth_bit_r <= 1'b0;
        end else if (rx_accept && mode[1]) begin
            rx_ninth_bit_r <= rx.ninth;
        end else if (rx.stop_pulse && mode == MODE_UART8 && !mp_active) begin
            rx_ninth_bit_r <= rx.stop_bit;
        end else if (ctrl_wr) begin
            rx_ninth_bit_r <= wr_data[SC_RX_NINTH];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_buf_r <= RST_BYTE;
        end else if (rx_accept) begin
            rx_buf_r <= rx.data;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fce_r <= 1'b0;
            station_address_r <= RST_BYTE;
            station_address_mask_r <= RST_BYTE;
            rx_div_r <= RST_BAUD_DIV;
            tx_div_r <= RST_BAUD_DIV;
        end else if (wr_en) begin
            case (addr)
                OFS_POWER_CONTROL: fce_r <= wr_data[PC_FRAME_CHECK];
                OFS_STATION_ADDRESS: station_address_r <= wr_data;
                OFS_STATION_MASK: station_address_mask_r <= wr_data;
                OFS_RX_BAUD_DIV: rx_div_r <= wr_data;
                OFS_TX_BAUD_DIV: tx_div_r <= wr_data;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmitter.

    logic [10:0] tx_sh_r;
    logic [3:0] tx_left_r;
    logic [7:0] tx_presc_r;
    logic [3:0] tx_sub_r;
    logic tx_bit_end;

    assign tx_bit_end = (tx_presc_r == tx_div_r) && (tx_sub_r == TICK_LAST);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_presc_r <= RST_BYTE;
            tx_sub_r <= 4'h0;
        end else if (tx_left_r == 4'h0 || tx_presc_r == tx_div_r) begin
            tx_presc_r <= RST_BYTE;
            tx_sub_r <= (tx_left_r == 4'h0) ? 4'h0 : tx_sub_r + 4'h1;
        end else begin
            tx_presc_r <= tx_presc_r + 8'h01;
        end
    end

    // Runs beside the receiver on its own divider.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_sh_r <= 11'h7FF;
            tx_left_r <= 4'h0;
            txd <= 1'b1;
        end else if (tx_left_r == 4'h0) begin
            txd <= 1'b1;
            if (sw_data && mode != MODE_SHIFT) begin
                tx_sh_r <= mode[1] ? {1'b1, tb8_r, wr_data, 1'b0} : {2'b11, wr_data, 1'b0};
                tx_left_r <= mode[1] ? 4'hB : 4'hA;
                txd <= 1'b0;
            end
        end else if (tx_bit_end) begin
            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
            tx_left_r <= tx_left_r - 4'h1;
            txd <= (tx_left_r == 4'h1) ? 1'b1 : tx_sh_r[1];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ti_r <= 1'b0;
        end else if (tx_bit_end && tx_left_r == 4'h2) begin
            ti_r <= 1'b1;
        end else if (ctrl_wr) begin
            ti_r <= wr_data[SC_TX_DONE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port and flag outputs.

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_data <= RST_BYTE;
        end else if (rd_en) begin
            case (addr)
                OFS_SERIAL_CONTROL: rd_data <= ctrl_view;
                OFS_POWER_CONTROL: rd_data <= {1'b0, fce_r, 6'h00};
                OFS_SERIAL_DATA: rd_data <= rx_buf_r;
                OFS_STATION_ADDRESS: rd_data <= station_address_r;
                OFS_STATION_MASK: rd_data <= station_address_mask_r;
                OFS_RX_BAUD_DIV: rd_data <= rx_div_r;
                OFS_TX_BAUD_DIV: rd_data <= tx_div_r;
                default: rd_data <= RST_BYTE;
            endcase
        end else begin
            rd_data <= RST_BYTE;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_done <= 1'b0;
            tx_done <= 1'b0;
        end else begin
            rx_done <= rx_done_flag_r;
            tx_done <= ti_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_hw_done_rise;
        $rose(rx_done_flag_r) && !$past(ctrl_wr);
    endsequence

    sequence s_bad_stop;
        rx.stop_pulse && fce_r && !rx.stop_bit;
    endsequence

    sequence s_mp_drop;
        rx_event && mp_active && !(addr_frame && addr_hit);
    endsequence

    // Framing error flag.
    a_ferr_only_checked: assert property ($rose(framing_error_flag_r) && !$past(ctrl_wr) |-> $past(fce_r))
        else $error("Framing error set while checking was off.");
    a_ferr_frozen_off: assert property (!fce_r |=> $stable(framing_error_flag_r))
        else $error("Framing error flag changed while checking was off.");
    a_ferr_bad_stop: assert property (s_bad_stop |=> framing_error_flag_r)
        else $error("Bad stop bit did not set the framing error flag.");
    a_ferr_set_wins: assert property (s_bad_stop ##0 ctrl_wr |=> framing_error_flag_r)
        else $error("Software write beat a framing error set.");
    a_ferr_sticky: assert property (framing_error_flag_r && !ctrl_wr |=> framing_error_flag_r)
        else $error("Framing error flag cleared without software.");

    // Receive-done flag and address recognition.
    a_done_at_stop: assert property (s_hw_done_rise and $past(fce_r) |-> $past(rx.stop_pulse))
        else $error("Receive-done rose away from the stop bit.");
    a_mode0_no_mp: assert property (s_hw_done_rise |-> $past(mode) != MODE_SHIFT)
        else $error("Receive-done raised in shift mode.");
    a_mp_off_all: assert property (rx_event && !mp_active |=> rx_done_flag_r)
        else $error("Frame dropped with address recognition off.");
    a_addr_drop: assert property (s_hw_done_rise and $past(mp_active) |-> $past(addr_hit && addr_frame))
        else $error("Non-matching address frame raised receive-done.");
    a_drop_keeps_buf: assert property (s_mp_drop |=> $stable(rx_buf_r))
        else $error("Dropped frame changed the receive buffer.");
    a_done_set_wins: assert property (rx_accept && ctrl_wr |=> rx_done_flag_r)
        else $error("Software write beat a receive-done set.");
    a_given_accept: assert property (rx_event && mp_active && addr_frame
        && (rx.data & station_address_mask_r) == (station_address_r & station_address_mask_r) |=> rx_done_flag_r)
        else $error("Given address match not accepted.");
    a_bcast_accept: assert property (rx_event && mp_active && addr_frame
        && (rx.data & bcast_addr) == bcast_addr |=> rx_done_flag_r)
        else $error("Broadcast address match not accepted.");
    a_clear_any: assert property (rx_event && mp_active && addr_frame
        && station_address_r == RST_BYTE && station_address_mask_r == RST_BYTE |=> rx_done_flag_r)
        else $error("Cleared station registers did not accept an address.");
    a_mode1_stop_ninth: assert property (s_hw_done_rise and $past(mp_active && mode == MODE_UART8)
        |-> $past(rx.stop_bit) && $past(rx.stop_pulse))
        else $error("Mode 1 address frame accepted without valid stop.");
    a_ninth_stored: assert property (s_hw_done_rise and $past(mode[1]) |-> rx_ninth_bit_r == $past(rx.ninth))
        else $error("Ninth bit not stored on receive.");
    a_stop_stored: assert property (rx.stop_pulse && mode == MODE_UART8 && !mp_active
        |=> rx_ninth_bit_r == $past(rx.stop_bit))
        else $error("Stop bit not stored in mode 1.");

    // Transmitter, read port and pins.
    a_tx_start_low: assert property (sw_data && mode != MODE_SHIFT && tx_left_r == 4'h0 |=> !txd)
        else $error("Transmit did not begin with a start bit.");
    a_tx_done_stop: assert property ($rose(ti_r) && !$past(ctrl_wr) |-> $past(tx_left_r) == 4'h2)
        else $error("Transmit-done rose away from the stop bit.");
    a_station_read: assert property (rd_en && addr == OFS_STATION_ADDRESS && !wr_en
        |=> rd_data == station_address_r)
        else $error("Station address read back wrong.");
    a_read_idle_zero: assert property (!rd_en |=> rd_data == RST_BYTE)
        else $error("Read data not zero outside a read.");
    a_done_pin_copy: assert property (rx_done == $past(rx_done_flag_r) && tx_done == $past(ti_r))
        else $error("Done pins do not follow their flags.");

endmodule // serial_port

// >>> testbench/serial_master.sv
module serial_master (
    input wire logic mclk,
    output logic rxd,
    input wire logic txd
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        rxd = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sends start, eight bits LSB first, an optional ninth bit, the chosen stop level and one idle bit.
    // The caller picks the address, all ones reaching every slave.
    task automatic send(input logic [7:0] d, input bit nine, input logic ninth, input logic stop);
        logic [10:0] bits;
        int n;
        n = nine ? 11 : 10;
        bits = nine ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            rxd <= bits[i];
            repeat (15) @(posedge mclk);
        end
        @(posedge mclk);
        rxd <= 1'b1;
        repeat (16) @(posedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Receives one byte from the transmit line at its own bit period.
    task automatic listen(input int per, output logic [7:0] d);
        d = 8'h00;
        for (int i = 0; i < 400 && txd !== 1'b0; i++) begin
            @(posedge mclk);
        end
        repeat (per / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (per) @(posedge mclk);
            d[i] = txd;
        end
    endtask
endmodule // serial_master

// >>> testbench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import serial_port_pkg::*;

    logic mclk, rst, wr_en, rd_en, rxd, txd, rx_done, tx_done;
    logic [7:0] addr, wr_data, rd_data;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;

    serial_port u_dut (.mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .rxd(rxd), .txd(txd), .rx_done(rx_done), .tx_done(tx_done));
    serial_master u_m (.mclk(mclk), .rxd(rxd), .txd(txd));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] msk, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(what, exp, v & msk);
    endtask

    // Clears the flags with a control write, sends a frame, then reads the control bits back.
    task automatic rxc(input logic [7:0] sc, d, input bit nine, input logic ninth, stop, input logic [7:0] msk, exp);
        wr(OFS_SERIAL_CONTROL, sc);
        u_m.send(d, nine, ninth, stop);
        rdchk("serial control", OFS_SERIAL_CONTROL, msk, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdchk("station address", OFS_STATION_ADDRESS, 8'hFF, 8'h00);
        rdchk("station mask", OFS_STATION_MASK, 8'hFF, 8'h00);
        rdchk("serial control", OFS_SERIAL_CONTROL, 8'hFF, 8'h00);
        rdchk("unmapped", 8'h00, 8'hFF, 8'h00);
        rxc(8'hF0, 8'h7F, 1'b1, 1'b1, 1'b1, 8'h01, 8'h01);
        $display("reset test done");
    endtask

    task automatic t_regs();
        wr(OFS_STATION_ADDRESS, 8'h56);
        wr(OFS_STATION_MASK, 8'hFC);
        rdchk("station address", OFS_STATION_ADDRESS, 8'hFF, 8'h56);
        rdchk("station mask", OFS_STATION_MASK, 8'hFF, 8'hFC);
        $display("register test done");
    endtask

    task automatic t_addr();
        // Given 0101 01XX, broadcast 1111 111X; the last entry is all ones.
        logic [7:0] ad [7] = '{8'h55, 8'h54, 8'h5E, 8'hFE, 8'h7F, 8'h55, 8'hFF};
        logic nb [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        logic ok [7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
        logic [7:0] last;
        last = 8'h7F;
        for (int i = 0; i < 7; i++) begin
            rxc(8'hF0, ad[i], 1'b1, nb[i], 1'b1, 8'h01, {7'h00, ok[i]});
            chk("rx done pin", {7'h00, ok[i]}, {7'h00, rx_done});
            last = ok[i] ? ad[i] : last;
            rdchk("rx buffer", OFS_SERIAL_DATA, 8'hFF, last);
        end
        rxc(8'hD0, 8'h7F, 1'b1, 1'b0, 1'b1, 8'h05, 8'h01);
        rxc(8'hD0, 8'h12, 1'b1, 1'b1, 1'b1, 8'h05, 8'h05);
        $display("address test done");
    endtask

    task automatic t_mode1();
        logic [7:0] sc [5] = '{8'h70, 8'h70, 8'h70, 8'h50, 8'h50};
        logic [7:0] d [5] = '{8'h56, 8'h57, 8'h56, 8'h56, 8'h56};
        logic st [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        logic [7:0] msk [5] = '{8'h01, 8'h01, 8'h01, 8'h05, 8'h05};
        logic [7:0] exp [5] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h05};
        wr(OFS_STATION_MASK, 8'hFF);
        for (int i = 0; i < 5; i++) begin
            rxc(sc[i], d[i], 1'b0, 1'b0, st[i], msk[i], exp[i]);
        end
        $display("mode 1 test done");
    endtask

    task automatic t_frame();
        wr(OFS_POWER_CONTROL, 8'h00);
        wr(OFS_SERIAL_CONTROL, 8'hD0);
        rdchk("mode bit 0", OFS_SERIAL_CONTROL, 8'h80, 8'h80);
        rxc(8'h50, 8'h3C, 1'b0, 1'b0, 1'b0, 8'h80, 8'h00);
        wr(OFS_POWER_CONTROL, 8'h40);
        rdchk("framing error", OFS_SERIAL_CONTROL, 8'h80, 8'h00);
        u_m.send(8'h3C, 1'b0, 1'b0, 1'b0);
        rdchk("framing error", OFS_SERIAL_CONTROL, 8'h80, 8'h80);
        u_m.send(8'hC3, 1'b0, 1'b0, 1'b1);
        rdchk("framing error", OFS_SERIAL_CONTROL, 8'h80, 8'h80);
        wr(OFS_SERIAL_CONTROL, 8'h50);
        rdchk("framing error", OFS_SERIAL_CONTROL, 8'h80, 8'h00);
        for (int c = 0; c < 2; c++) begin
            wr(OFS_POWER_CONTROL, c ? 8'h40 : 8'h00);
            wr(OFS_SERIAL_CONTROL, 8'h50);
            fork
                u_m.send(8'hA5, 1'b0, 1'b0, 1'b1);
                begin
                    repeat (147) @(posedge mclk);
                    chk("done before stop", {7'h00, c == 0}, {7'h00, rx_done});
                end
            join
        end
        $display("framing test done");
    endtask

    task automatic t_duplex();
        logic [7:0] got;
        wr(OFS_POWER_CONTROL, 8'h00);
        wr(OFS_TX_BAUD_DIV, 8'h01);
        wr(OFS_SERIAL_CONTROL, 8'h50);
        fork
            wr(OFS_SERIAL_DATA, 8'hA5);
            u_m.listen(32, got);
            u_m.send(8'h3C, 1'b0, 1'b0, 1'b1);
        join
        repeat (40) @(posedge mclk);
        chk("sent byte", 8'hA5, got);
        chk("tx done pin", 8'h01, {7'h00, tx_done});
        rdchk("rx buffer", OFS_SERIAL_DATA, 8'hFF, 8'h3C);
        $display("duplex test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_addr();
        t_mode1();
        t_frame();
        t_duplex();
        end_of_test();
    end
endmodule // tb
